// ---- rtl/supv_pkg.sv ----
// supv_pkg: constants and carrier types for the supply supervisor block.
// assumes a 50 MHz system clock and an 8-bit register port.
package supv_pkg;
    // system clock
    localparam int unsigned CLK_HZ          = 50_000_000;
    // power-on hold time in microseconds, times the clock in whole MHz (division rounds down)
    localparam int unsigned POR_HOLD_US     = 1000;
    localparam int unsigned POR_HOLD_CYC    = (POR_HOLD_US * (CLK_HZ / 1_000_000));

    // register map (byte offsets on the plain port)
    localparam logic [7:0] PFC_OFFSET       = 8'hdc;
    localparam logic [7:0] RSN_OFFSET       = 8'hb1;
    localparam logic [7:0] IST_OFFSET       = 8'hd0;
    localparam logic [7:0] IMK_OFFSET       = 8'hd1;

    // power_fail_control fields
    localparam int unsigned PFC_EN_BIT      = 7;
    localparam int unsigned PFC_LVL_LSB     = 5;
    localparam int unsigned PFC_WARN_BIT    = 4;
    localparam logic [7:0] PFC_RESET        = 8'h00;
    localparam logic [7:0] PFC_WMASK        = 8'he0;

    // reset_reason_record: all zero means on-chip reset generator
    localparam logic [2:0] RSN_GENERATOR    = 3'h0;
    localparam logic [2:0] RSN_RESET        = 3'h0;

    // interrupt status/mask layout
    localparam int unsigned IST_PF_BIT      = 0;
    localparam int unsigned IST_BO_BIT      = 1;
    localparam logic [1:0] IST_RESET        = 2'h0;
    localparam logic [1:0] IMK_RESET        = 2'h0;

    // falling thresholds selected by the level field
    typedef enum logic [1:0] {
        LVL_2V1,
        LVL_2V3,
        LVL_2V5,
        LVL_2V7
    } pf_level_t;

    // supply operating modes seen from the power manager
    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_STANDBY,
        MODE_RETENTION,
        MODE_DEEP_SLEEP
    } op_mode_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // analog comparator outputs, asynchronous to the clock
    typedef struct packed {
        logic supply_ok;   // supply above 1.9V operating level
        logic brown_low;   // brown-out comparator, hysteresis built in
        logic pf_low;      // power-fail comparator at selected level
    } cmp_in_t;
endpackage : supv_pkg

// ---- rtl/supv_sync.sv ----
// supv_sync: three-stage synchroniser with agreement filter for one level.
// assumes the input is asynchronous to i_clk.
`timescale 1ns/100ps
`default_nettype none
module supv_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_async,
    output logic      o_level
);
    logic       meta_r;
    logic [1:0] pipe_r;
    logic       level_r;

    // first stage feeds only the second; output moves when stages 2 and 3 agree
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r  <= RESET_VAL;
            pipe_r  <= {2{RESET_VAL}};
            level_r <= RESET_VAL;
        end else begin
            meta_r  <= i_async;
            pipe_r  <= {pipe_r[0], meta_r};
            if (pipe_r[0] == pipe_r[1]) begin
                level_r <= pipe_r[1];
            end
        end
    end

    assign o_level = level_r;
endmodule : supv_sync
`default_nettype wire

// ---- rtl/supv_top.sv ----
// supv_top: supply supervisor with power-on hold, brown-out reset and
// power-fail warning, flag, interrupt and program-write blocking.
// assumes analog comparators supply hysteresis; I_RST_B is the raw
// power-on start from the analog generator, asynchronous, active low.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module supv_top #(
    parameter int unsigned POR_CYCLES = supv_pkg::POR_HOLD_CYC
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RST_B,
    input  wire logic [7:0]        I_ADDR,
    input  wire logic [7:0]        I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    input  wire logic              I_SUPPLY_OK,
    input  wire logic              I_BROWN_LOW,
    input  wire logic              I_PF_LOW,
    input  wire logic [1:0]        I_OP_MODE,
    input  wire logic              I_PROG_WR_REQ,
    output logic [7:0]             O_RDATA,
    output logic                   O_SYS_RST_B,
    output logic                   O_PF_CMP_EN,
    output logic [1:0]             O_PF_LEVEL,
    output logic                   O_PROG_WR_EN,
    output logic                   O_PF_EVENT,
    output logic                   O_IRQ
);
    supv_pkg::reg_req_t req;
    supv_pkg::cmp_in_t  cmp;
    supv_pkg::op_mode_t mode;

    logic        run_mode;
    logic        supply_ok_s;
    logic        brown_low_s;
    logic        pf_low_s;
    logic        brown_active;
    logic [31:0] por_cnt_r;
    logic        sys_rst_b_r;
    logic [7:0]  pfc_r;
    logic        warn_r;
    logic        warn_d_r;
    logic        pf_event_r;
    logic        bo_event;
    logic        bo_seen_r;
    logic [2:0]  reason_r;
    logic [1:0]  ist_r;
    logic [1:0]  ist_nxt;
    logic [1:0]  imk_r;
    logic [7:0]  rdata_r;

    assign req  = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
    assign cmp  = '{supply_ok: I_SUPPLY_OK, brown_low: I_BROWN_LOW, pf_low: I_PF_LOW};
    assign mode = supv_pkg::op_mode_t'(I_OP_MODE);

    // brown-out and power-fail detectors only run in the two awake modes
    assign run_mode = (mode == supv_pkg::MODE_ACTIVE) || (mode == supv_pkg::MODE_STANDBY);

    // comparator outputs crossed into the clock domain
    supv_sync #(.RESET_VAL(1'b0)) u_sync_ok (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_async (cmp.supply_ok),
        .o_level (supply_ok_s)
    );
    supv_sync #(.RESET_VAL(1'b0)) u_sync_bo (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_async (cmp.brown_low),
        .o_level (brown_low_s)
    );
    supv_sync #(.RESET_VAL(1'b0)) u_sync_pf (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_async (cmp.pf_low),
        .o_level (pf_low_s)
    );

    // brown-out only counts in awake modes; the comparator carries the
    // 1.7V / 1.77V hysteresis so release waits for the upper level
    assign brown_active = brown_low_s && run_mode;
    assign bo_event     = brown_active && sys_rst_b_r;

    // hold counter restarts whenever supply is low or brown-out is active;
    // a brown-out release also waits the full hold, which is the safe side
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            por_cnt_r   <= 32'h0;
            sys_rst_b_r <= 1'b0;
        end else if (!supply_ok_s || brown_active) begin
            por_cnt_r   <= 32'h0;
            sys_rst_b_r <= 1'b0;
        end else if (por_cnt_r < POR_CYCLES) begin
            por_cnt_r   <= por_cnt_r + 32'h1;
            sys_rst_b_r <= 1'b0;
        end else begin
            sys_rst_b_r <= 1'b1;
        end
    end

    // power-fail has no path into the reset logic above
    assign O_SYS_RST_B = sys_rst_b_r;

    // control register: enable and level writable, warn is read-only
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pfc_r <= supv_pkg::PFC_RESET;
        end else if (!sys_rst_b_r) begin
            pfc_r <= supv_pkg::PFC_RESET;
        end else if (req.wr && req.addr == supv_pkg::PFC_OFFSET) begin
            pfc_r <= req.wdata & supv_pkg::PFC_WMASK;
        end
    end

    // comparator power and level select go to the analog side
    assign O_PF_CMP_EN = pfc_r[supv_pkg::PFC_EN_BIT] && run_mode;
    assign O_PF_LEVEL  = pfc_r[supv_pkg::PFC_LVL_LSB +: 2];

    // warning flag; comparator hysteresis gives the 0.1V release margin.
    // a powered-down comparator reports no warning
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            warn_r   <= 1'b0;
            warn_d_r <= 1'b0;
        end else begin
            warn_r   <= pf_low_s && O_PF_CMP_EN;
            warn_d_r <= warn_r;
        end
    end

    // one event per rising edge of the warning flag
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pf_event_r <= 1'b0;
        end else begin
            pf_event_r <= warn_r && !warn_d_r;
        end
    end
    assign O_PF_EVENT = pf_event_r;

    // program writes pass only while no warning stands
    assign O_PROG_WR_EN = I_PROG_WR_REQ && !warn_r && sys_rst_b_r;

    // remember a brown-out for the status bit across the reset it causes
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            bo_seen_r <= 1'b0;
        end else if (bo_event) begin
            bo_seen_r <= 1'b1;
        end else if (sys_rst_b_r) begin
            bo_seen_r <= 1'b0;
        end
    end

    // reset reason: generator resets clear it; write clears too
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            reason_r <= supv_pkg::RSN_RESET;
        end else if (!sys_rst_b_r) begin
            reason_r <= supv_pkg::RSN_GENERATOR;
        end else if (req.wr && req.addr == supv_pkg::RSN_OFFSET) begin
            reason_r <= supv_pkg::RSN_RESET;
        end
    end

    // sticky status: set wins over write-one-to-clear
    always_comb begin
        ist_nxt = ist_r;
        if (req.wr && req.addr == supv_pkg::IST_OFFSET) begin
            ist_nxt = ist_r & ~req.wdata[1:0];
        end
        if (pf_event_r) begin
            ist_nxt[supv_pkg::IST_PF_BIT] = 1'b1;
        end
        if (bo_seen_r && sys_rst_b_r) begin
            ist_nxt[supv_pkg::IST_BO_BIT] = 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ist_r <= supv_pkg::IST_RESET;
        end else begin
            ist_r <= ist_nxt;
        end
    end

    // mask survives brown-out so software need not re-arm it
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            imk_r <= supv_pkg::IMK_RESET;
        end else if (req.wr && req.addr == supv_pkg::IMK_OFFSET) begin
            imk_r <= req.wdata[1:0];
        end
    end

    assign O_IRQ = |(ist_r & imk_r);

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rdata_r <= 8'h00;
        end else if (!req.rd) begin
            rdata_r <= 8'h00;
        end else if (req.addr == supv_pkg::PFC_OFFSET) begin
            rdata_r <= {pfc_r[7:5], warn_r, 4'h0};
        end else if (req.addr == supv_pkg::RSN_OFFSET) begin
            rdata_r <= {5'h00, reason_r};
        end else if (req.addr == supv_pkg::IST_OFFSET) begin
            rdata_r <= {6'h00, ist_r};
        end else if (req.addr == supv_pkg::IMK_OFFSET) begin
            rdata_r <= {6'h00, imk_r};
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign O_RDATA = rdata_r;
endmodule : supv_top
`default_nettype wire

// ---- sim/supv_top_assertions.sv ----
// port-level checker for supv_top
// bound into supv_top by the bench; sees only its ports
`timescale 1ns/100ps
`default_nettype none
module supv_top_checker #(
    parameter int unsigned POR_CYCLES = supv_pkg::POR_HOLD_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic [7:0] I_ADDR,
    input wire logic I_RD,
    input wire logic I_SUPPLY_OK,
    input wire logic I_BROWN_LOW,
    input wire logic I_PF_LOW,
    input wire logic [1:0] I_OP_MODE,
    input wire logic I_PROG_WR_REQ,
    input wire logic [7:0] O_RDATA,
    input wire logic O_SYS_RST_B,
    input wire logic O_PF_CMP_EN,
    input wire logic [1:0] O_PF_LEVEL,
    input wire logic O_PROG_WR_EN,
    input wire logic O_PF_EVENT
);
    int unsigned good_r;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);
    // good-supply run length; saturates so it never wraps
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            good_r <= 0;
        end else if (!I_SUPPLY_OK || (I_BROWN_LOW && !I_OP_MODE[1])) begin
            good_r <= 0;
        end else if (good_r < 32'h000f_ffff) begin
            good_r <= good_r + 1;
        end
    end
    AST_POR_HOLD: assert property ($rose(O_SYS_RST_B) |-> good_r >= POR_CYCLES)
        else $error("reset released early");
    AST_BO_RESET: assert property ((I_BROWN_LOW && !I_OP_MODE[1]) [*8] |-> !O_SYS_RST_B)
        else $error("brown-out left reset high");
    AST_PF_NO_RST: assert property (
        (O_SYS_RST_B && I_SUPPLY_OK && !I_BROWN_LOW) [*8] |=> O_SYS_RST_B)
        else $error("reset without cause");
    AST_PROG_GATE: assert property (
        O_PROG_WR_EN |-> I_PROG_WR_REQ && O_SYS_RST_B && !O_PF_EVENT)
        else $error("program write passed");
    AST_CMP_MODE: assert property (O_PF_CMP_EN |-> !I_OP_MODE[1])
        else $error("comparator on in low mode");
    AST_EVT_PULSE: assert property (O_PF_EVENT |=> !O_PF_EVENT)
        else $error("event longer than one cycle");
    AST_EVT_CAUSE: assert property (
        O_PF_EVENT |-> $past(I_PF_LOW, 2) && $past(I_PF_LOW, 3) && O_PF_CMP_EN)
        else $error("event without low supply");
    AST_CTRL_READ: assert property (
        $past(I_RD) && $past(I_ADDR) == supv_pkg::PFC_OFFSET
        |-> O_RDATA[3:0] == 4'h0 && O_RDATA[6:5] == O_PF_LEVEL)
        else $error("control read wrong");
endmodule : supv_top_checker
`default_nettype wire

// ---- sim/supv_analog_model.sv ----
// behavioural supply comparators facing supv_top
// bench sets the supply in mV and moves it slowly
`timescale 1ns/100ps
`default_nettype none
module supv_analog_model (
    input wire logic [15:0] i_vdd_mv,
    input wire logic i_cmp_en,
    input wire logic [1:0] i_level,
    output var supv_pkg::cmp_in_t o_cmp
);
    int thr;
    initial o_cmp = '0;
    // hysteresis lives here; power-on detector arms once only
    always @(i_vdd_mv or i_cmp_en or i_level) begin
        thr = 2100 + 200 * i_level;
        if (i_vdd_mv >= 1900) o_cmp.supply_ok = 1'b1;
        if (i_vdd_mv < 1700) o_cmp.brown_low = 1'b1;
        else if (i_vdd_mv > 1770) o_cmp.brown_low = 1'b0;
        if (!i_cmp_en) o_cmp.pf_low = 1'b0;
        else if (i_vdd_mv < thr) o_cmp.pf_low = 1'b1;
        else if (i_vdd_mv > thr + 100) o_cmp.pf_low = 1'b0;
    end
endmodule : supv_analog_model
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for supv_top: bus, warning path, reset timing
// assumes a 50 MHz clock and a shortened power-on hold
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int POR = 20;
    localparam logic [7:0] PFC = supv_pkg::PFC_OFFSET;
    logic clk, rst_b, prog_req, sys_rst_b, cmp_en, prog_en, pf_event, irq;
    logic [1:0] mode, level;
    logic [7:0] rdata;
    logic [15:0] vdd;
    supv_pkg::reg_req_t req;
    supv_pkg::cmp_in_t cmp;
    int miscompares, n_checks, cyc, n, thr, ctrl_m;
    supv_top #(.POR_CYCLES(POR)) dut (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(req.addr),
        .I_WDATA(req.wdata), .I_WR(req.wr), .I_RD(req.rd), .I_SUPPLY_OK(cmp.supply_ok),
        .I_BROWN_LOW(cmp.brown_low), .I_PF_LOW(cmp.pf_low), .I_OP_MODE(mode),
        .I_PROG_WR_REQ(prog_req), .O_RDATA(rdata),
        .O_SYS_RST_B(sys_rst_b), .O_PF_CMP_EN(cmp_en), .O_PF_LEVEL(level),
        .O_PROG_WR_EN(prog_en), .O_PF_EVENT(pf_event), .O_IRQ(irq));
    supv_analog_model far (.i_vdd_mv(vdd), .i_cmp_en(cmp_en), .i_level(level), .o_cmp(cmp));
    always #10 clk = ~clk;
    // hang guard; the run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic pin(input logic got, input logic exp);
        check({7'h0, got}, {7'h0, exp});
    endtask : pin
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic wait_rst(input logic lvl);
        for (n = 0; sys_rst_b !== lvl && n < 400; n++) tick(1);
    endtask : wait_rst
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        mode = 2'h0;
        prog_req = 1'b0;
        vdd = 16'h0000;
        void'($urandom(3700));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        vdd <= 16'h0af0;
        wait_rst(1'b1);
        pin(sys_rst_b, 1'b1);
        pin(n >= POR, 1'b1);
        rd(PFC, supv_pkg::PFC_RESET);
        rd(supv_pkg::RSN_OFFSET, {5'h0, supv_pkg::RSN_GENERATOR});
        rd(8'h00, 8'h00);
        $display("test power_on done");
        // every level and mode; low bits random to prove them read-only
        for (int l = 0; l < 4; l++) begin
            ctrl_m = 8'h80 | (l << 5);
            wr(PFC, 8'(ctrl_m | $urandom_range(31)));
            rd(PFC, 8'(ctrl_m));
            check({6'h0, level}, 8'(l));
            @(posedge clk);
            mode <= 2'(l);
            tick(1);
            pin(cmp_en, l < 2);
        end
        @(posedge clk);
        mode <= 2'h0;
        $display("test levels done");
        n = $urandom_range(3);
        ctrl_m = 8'h80 | (n << 5);
        thr = 2100 + 200 * n;
        wr(PFC, 8'(ctrl_m));
        @(posedge clk);
        vdd <= 16'(thr - 30);
        prog_req <= 1'b1;
        for (n = 0; pf_event !== 1'b1 && n < 20; n++) tick(1);
        pin(pf_event, 1'b1);
        pin(sys_rst_b, 1'b1);
        pin(prog_en, 1'b0);
        tick(3);
        pin(pf_event, 1'b0);
        pin(irq, 1'b0);
        wr(supv_pkg::IMK_OFFSET, 8'h01);
        tick(1);
        pin(irq, 1'b1);
        rd(PFC, 8'(ctrl_m | 8'h10));
        wr(supv_pkg::IST_OFFSET, 8'h01);
        tick(1);
        pin(irq, 1'b0);
        @(posedge clk);
        vdd <= 16'(thr + 50);
        tick(10);
        rd(PFC, 8'(ctrl_m | 8'h10));
        @(posedge clk);
        vdd <= 16'(thr + 150);
        tick(10);
        rd(PFC, 8'(ctrl_m));
        pin(prog_en, 1'b1);
        $display("test power_fail done");
        wr(PFC, 8'h00);
        pin(cmp_en, 1'b0);
        @(posedge clk);
        mode <= 2'h2;
        vdd <= 16'h0672;
        tick(30);
        pin(sys_rst_b, 1'b1);
        @(posedge clk);
        mode <= 2'h0;
        wait_rst(1'b0);
        pin(sys_rst_b, 1'b0);
        wr(PFC, 8'h80);
        rd(PFC, 8'h00);
        rd(supv_pkg::RSN_OFFSET, 8'h00);
        @(posedge clk);
        vdd <= 16'h06cc;
        tick(40);
        pin(sys_rst_b, 1'b0);
        @(posedge clk);
        vdd <= 16'h0af0;
        wait_rst(1'b1);
        pin(sys_rst_b, 1'b1);
        pin(n >= POR, 1'b1);
        // brown-out status bit survives the reset it caused
        rd(supv_pkg::IST_OFFSET, 8'h02);
        $display("test brown_out done");
        wrap_up();
    end
endmodule : testbench
bind supv_top supv_top_checker #(.POR_CYCLES(POR_CYCLES)) chk (.I_CLK, .I_RST_B, .I_ADDR,
    .I_RD, .I_SUPPLY_OK, .I_BROWN_LOW, .I_PF_LOW, .I_OP_MODE, .I_PROG_WR_REQ, .O_RDATA,
    .O_SYS_RST_B, .O_PF_CMP_EN, .O_PF_LEVEL, .O_PROG_WR_EN, .O_PF_EVENT);
`default_nettype wire
